//--- sleep_wake_ctrl.sv
`timescale 1ns/1ps
module sleep_wake_ctrl
  import sleep_wake_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Serial port pins
  input wire logic cs_b,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso_out,
  output logic miso_oe_b,
  // Wake and status sources
  input wire logic bus_wake,
  input wire logic [2:0] local_wake_inputs,
  input wire logic main_undervolt,
  input wire logic battery_fail,
  // Power and status outputs
  output power_type power_out,
  output logic [2:0] mode_state,
  output logic spi_error
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [3:0] sync1_reg; // First stage, read only by second stage
  logic [3:0] sync2_reg; // Usable copies
  logic [2:0] lw1_reg;
  logic [2:0] lw2_reg;
  logic [2:0] lw_prev_reg; // Previous synced local level
  logic sclk_prev_reg;
  logic cs_prev_reg;

  // Two flops on each serial, bus wake and local wake pin before any use
  // Reset values match the idle pins: deselected, clock low, no bus wake,
  // so the edge finders see no false edge when reset lets go
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 4'h8;
      sync2_reg <= 4'h8;
      lw1_reg <= 3'h0;
      lw2_reg <= 3'h0;
    end else begin
      sync1_reg <= {cs_b, sclk, mosi, bus_wake};
      sync2_reg <= sync1_reg;
      lw1_reg <= local_wake_inputs;
      lw2_reg <= lw1_reg;
    end
  end

  wire cs_s = sync2_reg[3];
  wire sclk_s = sync2_reg[2];
  wire mosi_s = sync2_reg[1];
  wire bus_wake_s = sync2_reg[0];

  // Edge detection, clock edges masked while deselected
  wire sclk_fall = cs_prev_reg == 1'b0 && !cs_s && sclk_prev_reg && !sclk_s;
  wire sclk_rise = !cs_s && !sclk_prev_reg && sclk_s;
  wire cs_fall = cs_prev_reg && !cs_s;
  wire cs_rise = !cs_prev_reg && cs_s;

  // Previous synced levels for edge finding
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
      lw_prev_reg <= 3'h0;
    end else begin
      sclk_prev_reg <= sclk_s;
      cs_prev_reg <= cs_s;
      lw_prev_reg <= lw2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers and state

  typedef enum logic [1:0] {PM_ACTIVE, PM_SLEEP} power_mode_type;
  power_mode_type pmode_reg;

  logic [15:0] shift_in_reg; // Receive shift register
  logic [15:0] shift_out_reg; // Transmit shift register
  logic [4:0] bit_count_reg; // Bits taken this frame
  logic [2:0] mode_control_reg;
  logic [2:0] mode_validation_reg;
  logic [2:0] mode_state_reg;
  logic [3:0] supply_reg;
  logic [3:0] cycle_time_reg;
  // Wake control is kept as two halves so that each has one process:
  // the host writes the edge select, the hardware sets the source flags
  logic [1:0] wake_sel_reg; // Edge select, bits 1:0
  logic [1:0] wake_src_reg; // Select flag bit 3, bus flag bit 2
  wire [3:0] wake_ctrl_val = {wake_src_reg, wake_sel_reg}; // Register view
  logic wake_now; // Any armed wake event while asleep
  logic [3:0] irq_mask_two_reg; // Second mask, stored and read back only
  logic [3:0] wake_status_reg; // Local input flags
  logic [3:0] reset_cause_reg;
  logic [3:0] supply_status_reg;
  logic [3:0] irq_source_reg;
  logic [3:0] irq_mask_reg;
  logic [5:0] read_addr_reg; // Address of the last read, held until the next read
  logic read_pending_reg;
  logic miso_reg;
  logic [15:0] timer_reg; // Ticks within one timer step
  logic [4:0] period_reg; // Timer steps elapsed in the current sleep period
  logic [7:0] sense_reg; // Sense window counter
  logic [2:0] sense_hit_reg; // Previous sample matched

  ////////////////////////////////////////////////////////////////////////
  // Frame decode

  frame_type frame;
  assign frame = frame_type'(shift_in_reg);
  wire [3:0] parity_calc = {frame.data[3] ^ frame.data[0], frame.data[3] ^ frame.data[2],
                            frame.data[2] ^ frame.data[1], frame.data[1] ^ frame.data[0]};
  wire frame_full = bit_count_reg == 5'(FRAME_BITS);
  wire parity_ok = parity_calc == frame.parity;

  // Map of valid addresses
  wire addr_ok = frame.addr inside {ADDR_MODE_CONTROL, ADDR_MODE_VALIDATION, ADDR_SWITCHED_SUPPLY,
    ADDR_CYCLE_TIMING, ADDR_WATCHDOG, ADDR_GROUND_OFFSET, ADDR_WAKE_CONTROL, ADDR_WAKE_STATUS,
    ADDR_WAKE_LIVE, ADDR_OVERHEAT, ADDR_BUS_HIGH_ERR, ADDR_BUS_LOW_ERR, ADDR_RESET_CAUSE,
    ADDR_SUPPLY_STATUS, ADDR_IRQ_MASK_ONE, ADDR_IRQ_MASK_TWO, ADDR_IRQ_SOURCE_ONE, ADDR_IRQ_SOURCE_TWO};
  wire commit = cs_rise && frame_full;
  wire do_write = commit && frame.rw == RW_WRITE && parity_ok && addr_ok;
  wire bad_frame = commit && (!parity_ok || !addr_ok);
  // Read flags clear only after a complete frame
  wire read_done = commit && read_pending_reg && parity_ok;
  wire clr_wake_ctrl = read_done && read_addr_reg == ADDR_WAKE_CONTROL;
  wire clr_wake_stat = read_done && read_addr_reg == ADDR_WAKE_STATUS;
  wire clr_cause = read_done && read_addr_reg == ADDR_RESET_CAUSE;
  wire clr_supply = read_done && read_addr_reg == ADDR_SUPPLY_STATUS;

  // Read data selection once the address byte is in
  // While the eighth bit is still on the pin the address sits one place up,
  // above the first read/write flag; the mux must settle before that shift
  wire [5:0] addr_in = shift_in_reg[6:1];
  logic [3:0] read_data;
  always_comb begin
    case (addr_in)
      ADDR_MODE_CONTROL: read_data = {1'b0, mode_state_reg};
      ADDR_MODE_VALIDATION: read_data = {1'b0, mode_validation_reg};
      ADDR_SWITCHED_SUPPLY: read_data = supply_reg;
      ADDR_CYCLE_TIMING: read_data = cycle_time_reg;
      ADDR_WAKE_CONTROL: read_data = wake_ctrl_val;
      ADDR_WAKE_STATUS: read_data = wake_status_reg;
      ADDR_WAKE_LIVE: read_data = {1'b0, lw2_reg};
      ADDR_RESET_CAUSE: read_data = reset_cause_reg;
      ADDR_SUPPLY_STATUS: read_data = supply_status_reg;
      ADDR_IRQ_MASK_ONE: read_data = irq_mask_reg;
      ADDR_IRQ_MASK_TWO: read_data = irq_mask_two_reg;
      ADDR_IRQ_SOURCE_TWO: read_data = irq_source_reg;
      default: read_data = 4'h0;
    endcase
  end
  wire [3:0] rd_parity = {read_data[3] ^ read_data[0], read_data[3] ^ read_data[2],
                          read_data[2] ^ read_data[1], read_data[1] ^ read_data[0]};
  // Eighth bit taken with read flags zero: load parity and data
  wire load_read = sclk_fall && bit_count_reg == 5'd7 && shift_in_reg[0] == RW_READ[1]
                   && mosi_s == RW_READ[0];

  ////////////////////////////////////////////////////////////////////////
  // Serial shift engine

  // Shift in on falling edge, out on rising edge, MSB first
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_in_reg <= 16'h0000;
      shift_out_reg <= 16'h0000;
      bit_count_reg <= 5'h00;
      miso_reg <= 1'b0;
      read_pending_reg <= 1'b0;
      read_addr_reg <= 6'h00;
    end else begin
      if (cs_fall) begin
        bit_count_reg <= 5'h00;
        shift_out_reg <= shift_in_reg; // Echo previous frame
        miso_reg <= shift_in_reg[15];
        read_pending_reg <= 1'b0;
      end else if (sclk_fall && !frame_full) begin
        shift_in_reg <= {shift_in_reg[14:0], mosi_s};
        bit_count_reg <= bit_count_reg + 5'h01;
        if (load_read) begin
          shift_out_reg <= {rd_parity, read_data, 8'h00}; // Old top byte already gone
          read_pending_reg <= 1'b1;
          read_addr_reg <= addr_in;
        end
      end else if (sclk_rise) begin
        // Show the top bit, then shift: the first rise after select gives bit 15
        shift_out_reg <= {shift_out_reg[14:0], 1'b0};
        miso_reg <= shift_out_reg[15];
      end
      if (commit) begin
        read_pending_reg <= 1'b0;
      end
    end
  end

  // Driver enabled only while selected
  assign miso_out = miso_reg;
  assign miso_oe_b = cs_s;

  ////////////////////////////////////////////////////////////////////////
  // Control registers

  wire mode_match = mode_control_reg == frame.data[2:0];
  wire wake_pending = (|wake_src_reg) || (|wake_status_reg) || reset_cause_reg[CAUSE_UNDERVOLT_BIT]
                      || supply_status_reg[SUPPLY_BATFAIL_BIT];
  wire val_write = do_write && frame.addr == ADDR_MODE_VALIDATION;
  wire enter_sleep = val_write && mode_match && frame.data[2:0] == MODE_SLEEP && !wake_pending;

  // Host-written registers; the mode moves on a matched pair, or back to normal on a wake
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_control_reg <= MODE_NORMAL_REQ;
      mode_validation_reg <= MODE_NORMAL_REQ;
      mode_state_reg <= MODE_NORMAL_REQ;
      supply_reg <= SUPPLY_RESET;
      cycle_time_reg <= 4'h0;
      irq_mask_reg <= 4'h0;
      wake_sel_reg <= 2'h0;
      irq_mask_two_reg <= 4'h0;
    end else if (do_write) begin
      case (frame.addr)
        ADDR_MODE_CONTROL: mode_control_reg <= frame.data[2:0];
        ADDR_MODE_VALIDATION: begin
          mode_validation_reg <= frame.data[2:0];
          if (mode_match && (frame.data[2:0] != MODE_SLEEP || enter_sleep)) begin
            mode_state_reg <= frame.data[2:0];
          end
        end
        ADDR_SWITCHED_SUPPLY: supply_reg <= frame.data;
        ADDR_CYCLE_TIMING: cycle_time_reg <= frame.data;
        ADDR_WAKE_CONTROL: wake_sel_reg <= frame.data[1:0];
        ADDR_IRQ_MASK_ONE: irq_mask_reg <= frame.data;
        ADDR_IRQ_MASK_TWO: irq_mask_two_reg <= frame.data;
        default: mode_control_reg <= mode_control_reg;
      endcase
    end else if (pmode_reg == PM_SLEEP && wake_now) begin
      mode_state_reg <= MODE_NORMAL_REQ;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sleep and wake control

  wire cyclic_mode = supply_reg[SUP_CYCLIC_SENSE];
  wire forced_mode = supply_reg[SUP_FORCED_WAKE];
  wire step_done = timer_reg == 16'(TICK_CYCLES - 1);
  wire period_done = step_done && period_reg == {1'b0, cycle_time_reg};
  wire sense_on = cyclic_mode && sense_reg != 8'h00;
  wire sense_sample = sense_reg == 8'h01;

  // Selected state per input: 1 high, 2 low, 3 any change, 0 off
  logic [2:0] match;
  always_comb begin
    case (wake_sel_reg)
      2'h1: match = lw2_reg;
      2'h2: match = ~lw2_reg;
      2'h3: match = lw2_reg ^ lw_prev_reg;
      default: match = 3'h0;
    endcase
  end
  wire [2:0] local_hit = cyclic_mode ? (sense_sample ? (match & sense_hit_reg) : 3'h0) : match;
  wire sleeping = pmode_reg == PM_SLEEP;
  // Bus and select wake have no enable bit: they are always armed in sleep.
  // A select fall also wakes the chip before any frame bit has been taken,
  // so a host that talks to a sleeping chip still has its first frame shifted in and acted on
  assign wake_now = sleeping && (bus_wake_s || cs_fall || (forced_mode && period_done) || (|local_hit));

  // Power state machine with sleep timers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pmode_reg <= PM_ACTIVE;
      timer_reg <= 16'h0000;
      period_reg <= 5'h00;
      sense_reg <= 8'h00;
      sense_hit_reg <= 3'h0;
    end else begin
      case (pmode_reg)
        PM_ACTIVE: begin
          timer_reg <= 16'h0000;
          period_reg <= 5'h00;
          sense_hit_reg <= 3'h0;
          sense_reg <= 8'h00; // A stale window would fake a sample in the next sleep
          if (enter_sleep) begin
            pmode_reg <= PM_SLEEP;
          end
        end
        PM_SLEEP: begin
          timer_reg <= step_done ? 16'h0000 : timer_reg + 16'h0001;
          if (period_done) begin
            period_reg <= 5'h00;
            sense_reg <= 8'(SENSE_CYCLES);
          end else if (step_done) begin
            period_reg <= period_reg + 5'h01;
          end
          if (sense_reg != 8'h00 && !period_done) begin
            sense_reg <= sense_reg - 8'h01;
          end
          if (sense_sample) begin
            sense_hit_reg <= match; // Remember for two-in-a-row
          end
          if (wake_now) begin
            pmode_reg <= PM_ACTIVE;
          end
        end
        default: pmode_reg <= PM_ACTIVE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read-to-clear flags, set wins over clear

  // Sticky sources; a read that ends in the cycle of a new event keeps the flag,
  // so the host always sees it on the next read and, for all but the SPI error flag, sleep stays refused
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_src_reg <= 2'h0;
      wake_status_reg <= 4'h0;
      reset_cause_reg <= 4'h1; // Cold start reports undervoltage
      supply_status_reg <= 4'h3; // Battery fail and loss on cold start
      irq_source_reg <= 4'h0;
    end else begin
      wake_src_reg <= {sleeping && cs_fall, sleeping && bus_wake_s} | (clr_wake_ctrl ? 2'h0 : wake_src_reg);
      wake_status_reg <= {1'b0, sleeping ? local_hit : 3'h0} | (clr_wake_stat ? 4'h0 : wake_status_reg);
      reset_cause_reg[CAUSE_UNDERVOLT_BIT] <= main_undervolt
        || (reset_cause_reg[CAUSE_UNDERVOLT_BIT] && !clr_cause);
      supply_status_reg[SUPPLY_BATFAIL_BIT] <= battery_fail
        || (supply_status_reg[SUPPLY_BATFAIL_BIT] && !clr_supply);
      supply_status_reg[SUPPLY_BATLOSS_BIT] <= supply_status_reg[SUPPLY_BATLOSS_BIT] && !clr_supply;
      irq_source_reg[IRQ_SPI_ERR_BIT] <= bad_frame || (irq_source_reg[IRQ_SPI_ERR_BIT] && !read_done);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign power_out.main_on = !sleeping;
  assign power_out.secondary_on = !sleeping && mode_state_reg != MODE_NORMAL_REQ;
  assign power_out.switched_on = sleeping ? sense_on : supply_reg[SUP_INPUT_SUPPLY];
  assign mode_state = mode_state_reg;
  assign spi_error = irq_source_reg[IRQ_SPI_ERR_BIT];

endmodule : sleep_wake_ctrl

//--- sleep_wake_pkg.sv
package sleep_wake_pkg;

  // Register addresses (six-bit address field)
  localparam logic [5:0] ADDR_MODE_CONTROL = 6'h00;
  localparam logic [5:0] ADDR_MODE_VALIDATION = 6'h03;
  localparam logic [5:0] ADDR_SWITCHED_SUPPLY = 6'h05;
  localparam logic [5:0] ADDR_CYCLE_TIMING = 6'h06;
  localparam logic [5:0] ADDR_WATCHDOG = 6'h09;
  localparam logic [5:0] ADDR_GROUND_OFFSET = 6'h0a;
  localparam logic [5:0] ADDR_WAKE_CONTROL = 6'h0c;
  localparam logic [5:0] ADDR_WAKE_STATUS = 6'h0f;
  localparam logic [5:0] ADDR_WAKE_LIVE = 6'h11;
  localparam logic [5:0] ADDR_OVERHEAT = 6'h12;
  localparam logic [5:0] ADDR_BUS_HIGH_ERR = 6'h14;
  localparam logic [5:0] ADDR_BUS_LOW_ERR = 6'h17;
  localparam logic [5:0] ADDR_RESET_CAUSE = 6'h18;
  localparam logic [5:0] ADDR_SUPPLY_STATUS = 6'h1b;
  localparam logic [5:0] ADDR_IRQ_MASK_ONE = 6'h1d;
  localparam logic [5:0] ADDR_IRQ_MASK_TWO = 6'h1e;
  localparam logic [5:0] ADDR_IRQ_SOURCE_ONE = 6'h21;
  localparam logic [5:0] ADDR_IRQ_SOURCE_TWO = 6'h22;

  // Frame layout
  localparam int FRAME_BITS = 16;
  localparam logic [1:0] RW_WRITE = 2'h3;
  localparam logic [1:0] RW_READ = 2'h0;

  // Mode codes
  localparam logic [2:0] MODE_NORMAL_REQ = 3'h0;
  localparam logic [2:0] MODE_SLEEP = 3'h4;

  // Switched-supply bit positions
  localparam int SUP_CYCLIC_SENSE = 3;
  localparam int SUP_FORCED_WAKE = 2;
  localparam int SUP_INPUT_SUPPLY = 1;
  localparam int SUP_CYCLIC_INPUT = 0;
  localparam logic [3:0] SUPPLY_RESET = 4'h1;

  // Flag bit positions
  localparam int WAKE_BUS_BIT = 2;
  localparam int WAKE_CS_BIT = 3;
  localparam int CAUSE_UNDERVOLT_BIT = 0;
  localparam int SUPPLY_BATFAIL_BIT = 0;
  localparam int SUPPLY_BATLOSS_BIT = 1;
  localparam int IRQ_SPI_ERR_BIT = 0;

  // Timing: one timer step, cyclic sense on-time, both in microseconds
  localparam int CLK_NS = 100;
  localparam int TICK_US = 1000;
  localparam int SENSE_ON_US = 10;
  localparam int TICK_CYCLES = (TICK_US * 1000) / CLK_NS;
  localparam int SENSE_CYCLES = (SENSE_ON_US * 1000 + CLK_NS - 1) / CLK_NS;

  // Decoded serial frame
  typedef struct packed {
    logic [5:0] addr;
    logic [1:0] rw;
    logic [3:0] parity;
    logic [3:0] data;
  } frame_type;

  // Power outputs
  typedef struct packed {
    logic main_on;
    logic secondary_on;
    logic switched_on;
  } power_type;

endpackage : sleep_wake_pkg

//--- sleep_wake_props.sv
`timescale 1ns/1ps
module sleep_wake_props
  import sleep_wake_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Serial pins
  input wire logic cs_b,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe_b,
  // Wake and status sources
  input wire logic bus_wake,
  input wire logic [2:0] local_wake_inputs,
  input wire logic main_undervolt,
  input wire logic battery_fail,
  // Power and status outputs
  input wire power_type power_out,
  input wire logic [2:0] mode_state,
  input wire logic spi_error
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  // Steps of a select phase; four samples cover the pin synchroniser
  sequence deselected; cs_b [*4]; endsequence
  sequence selected; !cs_b [*4]; endsequence
  // Selected with the clock parked low long enough for the last shift to land
  sequence quiet_low; (!cs_b && !sclk) [*8]; endsequence
  sequence asleep; mode_state == MODE_SLEEP; endsequence
  ////////////////////////////////////////////////////////////////////////////////
  deselect_tristate_a: assert property (deselected |-> miso_oe_b)
    else $error("serial output driven while deselected");
  select_drive_a: assert property (selected |-> !miso_oe_b)
    else $error("serial output not driven while selected");
  miso_hold_a: assert property (quiet_low |-> $stable(miso_out))
    else $error("serial output moved without a clock rise");
  sleep_power_a: assert property (asleep |-> !power_out.main_on && !power_out.secondary_on)
    else $error("regulator on in sleep");
  wake_main_a: assert property ($past(mode_state) == MODE_SLEEP && mode_state != MODE_SLEEP |-> power_out.main_on)
    else $error("main regulator off after wake");
  sleep_entry_a: assert property ($changed(mode_state) && mode_state == MODE_SLEEP |-> cs_b && $past(cs_b))
    else $error("sleep entered outside a commit");
  bus_wake_a: assert property ($rose(bus_wake) && mode_state == MODE_SLEEP |-> ##[1:50] mode_state != MODE_SLEEP)
    else $error("bus wake ignored in sleep");
  err_set_a: assert property ($rose(spi_error) |-> cs_b)
    else $error("error flag set before frame end");
  err_clear_a: assert property ($fell(spi_error) |-> cs_b)
    else $error("error flag cleared before frame end");
endmodule : sleep_wake_props
bind sleep_wake_ctrl sleep_wake_props i_props (.ref_clk(ref_clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk),
  .mosi(mosi), .miso_out(miso_out), .miso_oe_b(miso_oe_b), .bus_wake(bus_wake),
  .local_wake_inputs(local_wake_inputs), .main_undervolt(main_undervolt), .battery_fail(battery_fail),
  .power_out(power_out), .mode_state(mode_state), .spi_error(spi_error));

//--- spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model
  import sleep_wake_pkg::*;
(
  // Pacing
  input wire logic ref_clk,
  input wire logic slow,
  // Serial pins
  output logic cs_b,
  output logic sclk,
  output logic mosi,
  input wire logic miso,
  // Word received in the last frame
  output logic rx_valid,
  output logic [15:0] rx_word
);
  // Idle: deselected, clock parked low
  initial begin
    cs_b = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
    rx_valid = 1'b0;
    rx_word = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One frame of n bits at an 800 ns serial period
  task automatic xfer(input frame_type f, input int n);
    logic [15:0] w;
    w = f;
    @(negedge ref_clk);
    cs_b = 1'b0; // Select with the clock low
    repeat (slow ? 20 : 12) @(negedge ref_clk);
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      mosi = w[15 - i]; // Most significant first, steady over the fall
      repeat (4) @(negedge ref_clk);
      sclk = 1'b0;
      repeat (2) @(negedge ref_clk);
      rx_word = {rx_word[14:0], miso}; // Taken mid low phase, clear of the next rise
      repeat (2) @(negedge ref_clk);
    end
    cs_b = 1'b1; // Deselect with the clock low
    mosi = ~mosi; // Released line does not keep the last bit
    rx_valid = 1'b1;
    @(negedge ref_clk);
    rx_valid = 1'b0;
    repeat (slow ? 40 : 10) @(negedge ref_clk);
  endtask : xfer
endmodule : spi_host_model

//--- testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; $display("Error %s expected %h seen %h", nm, e, a); end end
module testbench;
  import sleep_wake_pkg::*;
  // Stimulus and bookkeeping
  logic ref_clk, rst_b, bus_wake, main_undervolt, battery_fail, slow, sw;
  logic [2:0] local_wake_inputs, mode_state;
  logic [31:0] seed = 32'h0000f538;
  logic [7:0] exp_q[$]; // Per frame: read mask, expected data
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  int k;
  wire cs_b, sclk, mosi, miso_out, miso_oe_b, rx_valid, spi_error;
  wire [15:0] rx_word;
  power_type power_out;
  // Pull-up holds the released serial output high
  wire miso_line = miso_oe_b ? 1'b1 : miso_out;
  sleep_wake_ctrl i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk), .mosi(mosi),
    .miso_out(miso_out), .miso_oe_b(miso_oe_b), .bus_wake(bus_wake), .local_wake_inputs(local_wake_inputs),
    .main_undervolt(main_undervolt), .battery_fail(battery_fail), .power_out(power_out),
    .mode_state(mode_state), .spi_error(spi_error));
  spi_host_model i_host (.ref_clk(ref_clk), .slow(slow), .cs_b(cs_b), .sclk(sclk), .mosi(mosi),
    .miso(miso_line), .rx_valid(rx_valid), .rx_word(rx_word));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Parity is XOR of neighbouring data bits
  function automatic logic [3:0] par(input logic [3:0] d);
    return {d[3] ^ d[0], d[3] ^ d[2], d[2] ^ d[1], d[1] ^ d[0]};
  endfunction : par
  task automatic fr(input frame_type f, input int n, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.xfer(f, n);
  endtask : fr
  task automatic wr(input logic [5:0] a, input logic [3:0] d);
    fr({a, RW_WRITE, par(d), d}, 16, 8'h00);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [3:0] m, input logic [3:0] d);
    fr({a, RW_READ, 8'h00}, 16, {m, d});
  endtask : rd
  // Supply setting, then the matched pair of mode writes
  task automatic sleep_req(input logic [3:0] sup);
    wr(ADDR_SWITCHED_SUPPLY, sup);
    wr(ADDR_MODE_CONTROL, {1'b0, MODE_SLEEP});
    wr(ADDR_MODE_VALIDATION, {1'b0, MODE_SLEEP});
  endtask : sleep_req
  // Bounded wait for wake; k counts cycles, sw notes any sense pulse
  task automatic wake_wait(input int lim);
    k = 0;
    sw = 1'b0;
    while (mode_state === MODE_SLEEP && k < lim) begin
      @(negedge ref_clk);
      k++;
      sw |= power_out.switched_on;
    end
    `CHK("main on", 1'b1, power_out.main_on)
  endtask : wake_wait
  // Read-to-clear registers emptied before the next sleep
  task automatic clear_flags();
    rd(ADDR_WAKE_CONTROL, 4'h0, 4'h0);
    rd(ADDR_WAKE_STATUS, 4'h0, 4'h0);
    rd(ADDR_RESET_CAUSE, 4'h0, 4'h0);
    rd(ADDR_SUPPLY_STATUS, 4'h0, 4'h0);
  endtask : clear_flags
  task automatic stop_test();
    $display("Mismatches %0d of %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////////
  // Oldest note is matched against each finished frame
  always @(posedge rx_valid) begin : monitor
    logic [7:0] e;
    e = exp_q.pop_front();
    if (e[7:4] != 4'h0) begin
      `CHK("read data", e[3:0] & e[7:4], rx_word[3:0] & e[7:4])
      if (e[7:4] == 4'hf) `CHK("read parity", par(e[3:0]), rx_word[7:4])
    end
  end
  // Hang guard: the sleep timers dominate, well under this ceiling
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    logic [31:0] d;
    logic [5:0] ra [4];
    int j;
    logic [1:0] es;
    ra = '{ADDR_CYCLE_TIMING, ADDR_IRQ_MASK_ONE, ADDR_IRQ_MASK_TWO, ADDR_SWITCHED_SUPPLY};
    {rst_b, bus_wake, slow, sw, local_wake_inputs} = '0;
    {main_undervolt, battery_fail} = 2'h3;
    repeat (3) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (2) @(negedge ref_clk);
    {main_undervolt, battery_fail} = 2'h0;
    repeat (3) @(negedge ref_clk);
    `CHK("idle oe", 1'b1, miso_oe_b)
    // Power-up flags read once, then gone
    rd(ADDR_RESET_CAUSE, 4'h1, 4'h1);
    rd(ADDR_RESET_CAUSE, 4'h1, 4'h0);
    rd(ADDR_SUPPLY_STATUS, 4'h3, 4'h3);
    rd(ADDR_SUPPLY_STATUS, 4'h1, 4'h0);
    rd(ADDR_WAKE_CONTROL, 4'h0, 4'h0);
    rd(ADDR_SWITCHED_SUPPLY, 4'hf, SUPPLY_RESET);
    // Random write and read-back, prompt and slow host
    for (int i = 0; i < 4; i++) begin
      d = xs();
      slow = d[4];
      wr(ra[i], d[3:0]);
      rd(ra[i], 4'hf, d[3:0]);
    end
    slow = 1'b0;
    // Bad parity, short frame and bad address are all dropped
    d = xs();
    wr(ADDR_CYCLE_TIMING, d[3:0]);
    fr({ADDR_CYCLE_TIMING, RW_WRITE, ~par(d[3:0]), ~d[3:0]}, 16, 8'h00);
    `CHK("error set", 1'b1, spi_error)
    fr({ADDR_CYCLE_TIMING, RW_WRITE, par(~d[3:0]), ~d[3:0]}, 8, 8'h00);
    fr({6'h01, RW_WRITE, par(d[3:0]), d[3:0]}, 16, 8'h00);
    rd(ADDR_IRQ_SOURCE_TWO, 4'h1, 4'h1);
    rd(ADDR_CYCLE_TIMING, 4'hf, d[3:0]);
    `CHK("error clear", 1'b0, spi_error)
    // Sleep with bus and select wake only; mode needs both writes
    wr(ADDR_SWITCHED_SUPPLY, 4'h0);
    wr(ADDR_MODE_CONTROL, {1'b0, MODE_SLEEP});
    `CHK("half pair", MODE_NORMAL_REQ, mode_state)
    wr(ADDR_MODE_VALIDATION, {1'b0, MODE_SLEEP});
    `CHK("asleep", MODE_SLEEP, mode_state)
    `CHK("regs off", 2'h0, {power_out.main_on, power_out.secondary_on})
    bus_wake = 1'b1;
    wake_wait(100);
    bus_wake = 1'b0;
    rd(ADDR_WAKE_CONTROL, 4'h4, 4'h4);
    // Select wake leaves a flag that blocks sleep until read
    sleep_req(4'h0);
    fr({ADDR_OVERHEAT, RW_READ, 8'h00}, 8, 8'h00);
    `CHK("select wake", 1'b1, power_out.main_on)
    sleep_req(4'h0);
    `CHK("refused", MODE_NORMAL_REQ, mode_state)
    fr({ADDR_WAKE_CONTROL, RW_READ, 8'h00}, 12, 8'h00);
    rd(ADDR_WAKE_CONTROL, 4'h8, 4'h8);
    // Forced wake after one timer step
    wr(ADDR_CYCLE_TIMING, 4'h0);
    sleep_req(4'h4);
    `CHK("forced sleep", MODE_SLEEP, mode_state)
    wake_wait(TICK_CYCLES + 400);
    `CHK("forced time", 1'b1, k > TICK_CYCLES - 200)
    clear_flags();
    // Direct local wake on a random input with a random edge select
    d = xs();
    j = int'(d % 32'd3);
    es = 2'(32'd1 + (d >> 8) % 32'd3);
    local_wake_inputs = (es == 2'h2) ? 3'h7 : 3'h0;
    wr(ADDR_WAKE_CONTROL, {2'h0, es});
    sleep_req(4'h0);
    `CHK("no supply", 1'b0, power_out.switched_on)
    local_wake_inputs[j] = ~local_wake_inputs[j];
    wake_wait(20);
    `CHK("direct fast", 1'b1, k < 20)
    local_wake_inputs = 3'h0;
    rd(ADDR_WAKE_STATUS, 4'h7, 4'h1 << j);
    clear_flags();
    // Cyclic sense: two high samples needed
    wr(ADDR_WAKE_CONTROL, 4'h1);
    sleep_req(4'ha);
    `CHK("cyclic sleep", MODE_SLEEP, mode_state)
    local_wake_inputs[j] = 1'b1;
    wake_wait(2 * TICK_CYCLES + 1000);
    `CHK("cyclic late", 1'b1, k > TICK_CYCLES)
    `CHK("sense supply", 1'b1, sw)
    local_wake_inputs = 3'h0;
    clear_flags();
    stop_test();
  end
endmodule : testbench
